// ### hw/spi_duplex_pkg.sv
// Shared constants and types for the duplex serial register port
package spi_duplex_pkg;

  // ==========================================================
  // Byte and command layout
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned ADDR_W        = 5;
  localparam int unsigned CMD_ADDR_MSB  = 7;
  localparam int unsigned CMD_ADDR_LSB  = 3;
  localparam int unsigned CMD_WRITE_BIT = 1;
  localparam int unsigned NUM_REGS      = 32;
  localparam logic [2:0]  LAST_BIT      = 3'h7;

  // ==========================================================
  // Register map and reset values
  localparam logic [4:0]  STATUS_ADDR   = 5'h0d;
  localparam logic [4:0]  CTRL_ADDR     = 5'h11;
  localparam int unsigned FDUP_BIT      = 4;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;

  // ==========================================================
  // Link timing for the clock-making end
  localparam int unsigned SYS_PERIOD_PS    = 5000;
  localparam int unsigned SCLK_PERIOD_PS   = 125000;
  localparam int unsigned SCLK_HALF_CYCLES =
    (SCLK_PERIOD_PS / 2 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam logic [3:0]  HALF_RELOAD      = 4'(SCLK_HALF_CYCLES - 1);

  // ==========================================================
  // Clock-making end states, Gray along the bit loop
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_SEL  = 3'b001,
    M_LOW  = 3'b011,
    M_HIGH = 3'b010,
    M_END  = 3'b110,
    M_GAP  = 3'b111
  } mst_state_t;

endpackage

// ### hw/spi_link_if.sv
// Serial link between the register port and its clock-making partner
`timescale 1ns/1ps
`default_nettype none

interface spi_link_if;
  logic ss_n;
  logic sclk;
  logic mosi_m_o;
  logic mosi_m_oe_n;
  logic mosi_s_o;
  logic mosi_s_oe_n;
  logic miso_o;
  logic miso_oe_n;
  logic mosi;
  logic miso;

  // ==========================================================
  // Wire levels; an undriven pin floats to a pulled-up high
  assign mosi = !mosi_m_oe_n ? mosi_m_o : (!mosi_s_oe_n ? mosi_s_o : 1'b1);
  assign miso = !miso_oe_n ? miso_o : 1'b1;

  modport dev (input ss_n, sclk, mosi, output mosi_s_o, mosi_s_oe_n, miso_o, miso_oe_n);
  modport mst (input mosi, miso, output ss_n, sclk, mosi_m_o, mosi_m_oe_n);
endinterface

`default_nettype wire

// ### hw/spi_mst_end.sv
// Clock-making end: runs select, clock and data for register accesses
`timescale 1ns/1ps
`default_nettype none

module spi_mst_end (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Serial link
  spi_link_if.mst          link,
  // Mode
  input  wire logic        cpol,
  input  wire logic        full_duplex,
  // Command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic [7:0]  cmd_len,
  // Write data
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [7:0]  tx_data,
  // Read data
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [7:0]       rx_data,
  // Status byte seen during the command
  output logic             status_strobe,
  output logic [7:0]       status_byte
);
  spi_duplex_pkg::mst_state_t st_q;
  logic [3:0] div_q;
  logic [2:0] bit_q;
  logic [7:0] left_q, sh_q, in_q, spare_q;
  logic       wr_q, data_q, fd_q, cpol_q, spare_v_q;
  logic       miso_m_q, miso_s_q, mosi_m_q, mosi_s_q;
  logic       ss_n_q, sclk_q, mo_q, mo_oe_n_q, cmd_ready_q, tx_ready_q;
  logic       rx_valid_q, stat_q;
  logic [7:0] rx_q, stat_byte_q;

  // ==========================================================
  // Decode
  wire        tick     = (div_q == 4'h0);
  wire        take     = cmd_valid & cmd_ready_q;
  wire        tx_take  = tx_valid & tx_ready_q;
  wire        sample   = fd_q ? miso_s_q : mosi_s_q;
  wire [7:0]  in_byte  = {in_q[6:0], sample};
  wire        rise_t   = (st_q == spi_duplex_pkg::M_LOW) & tick;
  wire        byte_end = rise_t & (bit_q == spi_duplex_pkg::LAST_BIT);
  wire        push     = byte_end & data_q & !wr_q;
  wire        bound    = (st_q == spi_duplex_pkg::M_HIGH) & (bit_q == 3'h0);
  wire        go       = bound & (left_q != 8'h0) & (wr_q ? tx_take : (tick & !spare_v_q));
  wire        pop      = rx_valid_q & rx_ready;
  wire        head_in  = !rx_valid_q | pop;

  assign link.ss_n        = ss_n_q;
  assign link.sclk        = sclk_q;
  assign link.mosi_m_o    = mo_q;
  assign link.mosi_m_oe_n = mo_oe_n_q;
  assign cmd_ready     = cmd_ready_q;
  assign tx_ready      = tx_ready_q;
  assign rx_valid      = rx_valid_q;
  assign rx_data       = rx_q;
  assign status_strobe = stat_q;
  assign status_byte   = stat_byte_q;

  // ==========================================================
  // Input synchronisers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {miso_m_q, miso_s_q, mosi_m_q, mosi_s_q} <= 4'hf;
    end else begin
      {miso_m_q, mosi_m_q} <= {link.miso, link.mosi};
      {miso_s_q, mosi_s_q} <= {miso_m_q, mosi_m_q};
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= spi_duplex_pkg::M_IDLE;
      {div_q, bit_q, left_q, sh_q, in_q} <= '0;
      {wr_q, data_q, fd_q, cpol_q, sclk_q, mo_q, cmd_ready_q, tx_ready_q} <= '0;
      {ss_n_q, mo_oe_n_q} <= 2'b11;
      {stat_q, stat_byte_q} <= '0;
    end else begin
      div_q       <= (tick | go | take) ? spi_duplex_pkg::HALF_RELOAD : div_q - 4'h1;
      cmd_ready_q <= (st_q == spi_duplex_pkg::M_IDLE) & !take;
      // Offered only on the tick so the stretched high half is never cut short
      tx_ready_q  <= bound & wr_q & (left_q != 8'h0) & !tx_take & (div_q == 4'h1);
      stat_q      <= byte_end & !data_q & fd_q;
      if (byte_end & !data_q & fd_q) stat_byte_q <= in_byte;
      // Idle clock follows the mode input, so it has settled before select falls
      if (st_q == spi_duplex_pkg::M_IDLE) sclk_q <= cpol;
      case (st_q)
        spi_duplex_pkg::M_IDLE: if (take) begin
          sclk_q    <= cpol;
          ss_n_q    <= 1'b0;
          mo_q      <= cmd_byte[7];
          mo_oe_n_q <= 1'b0;
          sh_q      <= cmd_byte;
          left_q    <= cmd_len;
          wr_q      <= cmd_byte[spi_duplex_pkg::CMD_WRITE_BIT];
          {fd_q, cpol_q} <= {full_duplex, cpol};
          {bit_q, data_q} <= '0;
          st_q      <= spi_duplex_pkg::M_SEL;
        end
        spi_duplex_pkg::M_SEL: if (tick) begin
          sclk_q <= 1'b0;
          st_q   <= spi_duplex_pkg::M_LOW;
        end
        spi_duplex_pkg::M_LOW: if (tick) begin
          sclk_q <= 1'b1;
          in_q   <= in_byte;
          bit_q  <= bit_q + 3'h1;
          st_q   <= spi_duplex_pkg::M_HIGH;
        end
        spi_duplex_pkg::M_HIGH: begin
          if (bit_q != 3'h0 && tick) begin
            sclk_q <= 1'b0;
            sh_q   <= {sh_q[6:0], 1'b0};
            mo_q   <= sh_q[6];
            st_q   <= spi_duplex_pkg::M_LOW;
          end else if (go) begin
            sclk_q <= 1'b0;
            left_q <= left_q - 8'h1;
            data_q <= 1'b1;
            sh_q   <= wr_q ? tx_data : spi_duplex_pkg::ZERO_BYTE;
            mo_q   <= wr_q & tx_data[7];
            mo_oe_n_q <= !(wr_q | fd_q);
            st_q   <= spi_duplex_pkg::M_LOW;
          end else if (bit_q == 3'h0 && left_q == 8'h0 && tick) begin
            sclk_q <= cpol_q;
            st_q   <= spi_duplex_pkg::M_END;
          end
        end
        spi_duplex_pkg::M_END: if (tick) begin
          ss_n_q    <= 1'b1;
          mo_oe_n_q <= 1'b1;
          st_q      <= spi_duplex_pkg::M_GAP;
        end
        spi_duplex_pkg::M_GAP: if (tick) st_q <= spi_duplex_pkg::M_IDLE;
        default: st_q <= spi_duplex_pkg::M_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Two-entry read buffer; a full buffer holds the clock at the byte edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {rx_valid_q, spare_v_q, rx_q, spare_q} <= '0;
    end else begin
      if (head_in) begin
        rx_valid_q <= spare_v_q | push;
        rx_q       <= spare_v_q ? spare_q : in_byte;
        spare_v_q  <= spare_v_q & push;
        if (spare_v_q) spare_q <= in_byte;
      end else if (push) begin
        spare_v_q <= 1'b1;
        spare_q   <= in_byte;
      end
    end
  end
endmodule

`default_nettype wire

// ### hw/spi_dev_end.sv
// Register port end: serial slave with full- and half-duplex data pins
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Deselected full-duplex port floats output
// - Full-duplex select fall presents first status bit
// - Sample on rising, change on falling
// - Master may stop after command byte
// - Reads burst further bytes, MSB first
// - Clock idle before select falls
// - Full-duplex reads ignore data input
// - Master changes write data on falling
// - Full-duplex writes: status, then zeros
// - Half-duplex at reset and when cleared
// - Half-duplex: output floats, data shared
// - Half-duplex: status only by register read
// - Master drives command first at select
// - Half-duplex read turns pin around
// - Deselect drops partial byte, resets port
// - All bytes most significant bit first
// - Both clock polarities, rising-edge sample
// - Control bit four selects full duplex
module spi_dev_end (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Serial link
  spi_link_if.dev          link,
  // Live status byte
  input  wire logic [7:0]  status_in,
  // Current data-pin mode
  output logic             full_duplex,
  // Register write report
  output logic             wr_strobe,
  output logic [4:0]       wr_addr,
  output logic [7:0]       wr_data
);
  logic [7:0] mem_q [spi_duplex_pkg::NUM_REGS];
  logic [7:0] ctrl_q;
  logic       ss_m_q, ss_s_q, ss_p_q;
  logic       sclk_m_q, sclk_s_q, sclk_p_q;
  logic       mosi_m_q, mosi_s_q;
  logic [2:0] bit_q;
  logic [6:0] rx_q;
  logic [7:0] tx_q;
  logic       rose_q, cmd_done_q, wr_q;
  logic [4:0] addr_q;
  logic       miso_oe_n_q, mosi_oe_n_q;
  logic       wr_strobe_q;
  logic [4:0] wr_addr_q;
  logic [7:0] wr_data_q;

  // ==========================================================
  // Decode
  wire        fd        = ctrl_q[spi_duplex_pkg::FDUP_BIT];
  wire        sel       = !ss_s_q;
  wire        sel_start = sel & ss_p_q;
  wire        rise      = sel & sclk_s_q & !sclk_p_q;
  wire        fall      = sel & !sclk_s_q & sclk_p_q & rose_q;
  wire [7:0]  rx_byte   = {rx_q, mosi_s_q};
  wire        byte_end  = rise & (bit_q == spi_duplex_pkg::LAST_BIT);
  wire        cmd_end   = byte_end & !cmd_done_q;
  wire        data_wr   = byte_end & cmd_done_q & wr_q;
  wire        is_status = (addr_q == spi_duplex_pkg::STATUS_ADDR);
  wire        is_ctrl   = (addr_q == spi_duplex_pkg::CTRL_ADDR);
  wire [7:0]  rd_byte   = is_status ? status_in : (is_ctrl ? ctrl_q : mem_q[addr_q]);
  wire [7:0]  next_tx   = (cmd_done_q & !wr_q) ? rd_byte : spi_duplex_pkg::ZERO_BYTE;
  wire        hd_read   = !fd & cmd_done_q & !wr_q;

  assign link.miso_o      = tx_q[7];
  assign link.miso_oe_n   = miso_oe_n_q;
  assign link.mosi_s_o    = tx_q[7];
  assign link.mosi_s_oe_n = mosi_oe_n_q;
  assign full_duplex = ctrl_q[spi_duplex_pkg::FDUP_BIT];
  assign wr_strobe   = wr_strobe_q;
  assign wr_addr     = wr_addr_q;
  assign wr_data     = wr_data_q;

  // ==========================================================
  // Pin synchronisers; a third stage only feeds edge detection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {ss_m_q, ss_s_q, ss_p_q} <= 3'b111;
      {sclk_m_q, sclk_s_q, sclk_p_q} <= 3'b000;
      {mosi_m_q, mosi_s_q} <= 2'b11;
    end else begin
      {ss_m_q, sclk_m_q, mosi_m_q} <= {link.ss_n, link.sclk, link.mosi};
      {ss_s_q, sclk_s_q, mosi_s_q} <= {ss_m_q, sclk_m_q, mosi_m_q};
      {ss_p_q, sclk_p_q} <= {ss_s_q, sclk_s_q};
    end
  end

  // ==========================================================
  // Bit and byte framing
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {bit_q, rx_q, rose_q, cmd_done_q, wr_q, addr_q} <= '0;
    end else if (!sel) begin
      {bit_q, rx_q, rose_q, cmd_done_q} <= '0;
    end else begin
      if (rise) begin
        rx_q   <= rx_byte[6:0];
        bit_q  <= bit_q + 3'h1;
        rose_q <= 1'b1;
      end else if (fall) begin
        rose_q <= 1'b0;
      end
      if (cmd_end) begin
        cmd_done_q <= 1'b1;
        addr_q <= rx_byte[spi_duplex_pkg::CMD_ADDR_MSB:spi_duplex_pkg::CMD_ADDR_LSB];
        wr_q   <= rx_byte[spi_duplex_pkg::CMD_WRITE_BIT];
      end
    end
  end

  // ==========================================================
  // Output shifter; loads at select, then changes only after a sampled rise
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_q <= spi_duplex_pkg::ZERO_BYTE;
    end else if (!sel) begin
      tx_q <= spi_duplex_pkg::ZERO_BYTE;
    end else if (sel_start) begin
      tx_q <= fd ? status_in : spi_duplex_pkg::ZERO_BYTE;
    end else if (fall) begin
      tx_q <= (bit_q == 3'h0) ? next_tx : {tx_q[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Pin drivers; the output pin takes its mode once per frame, so a control
  // write inside an access cannot switch the pin under the master
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      miso_oe_n_q <= 1'b1;
    end else if (!sel) begin
      miso_oe_n_q <= 1'b1;
    end else if (sel_start) begin
      miso_oe_n_q <= !fd;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mosi_oe_n_q <= 1'b1;
    end else if (!sel || fd) begin
      mosi_oe_n_q <= 1'b1;
    end else if (fall && bit_q == 3'h0 && hd_read) begin
      mosi_oe_n_q <= 1'b0;
    end
  end

  // ==========================================================
  // Control register; half duplex after reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= spi_duplex_pkg::CTRL_RESET;
    end else if (data_wr && is_ctrl) begin
      ctrl_q <= rx_byte;
    end
  end

  // Plain storage; contents are undefined until first written
  always_ff @(posedge sys_clk) begin
    if (data_wr && !is_ctrl && !is_status) begin
      mem_q[addr_q] <= rx_byte;
    end
  end

  // ==========================================================
  // Write report
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {wr_strobe_q, wr_addr_q, wr_data_q} <= '0;
    end else begin
      wr_strobe_q <= data_wr;
      if (data_wr) begin
        wr_addr_q <= addr_q;
        wr_data_q <= rx_byte;
      end
    end
  end
endmodule

`default_nettype wire

// ### tb/spi_slave_duplex_port_properties.sv
// Concurrent checks on the serial link between the two ends
`timescale 1ns/1ps
`default_nettype none

module spi_slave_duplex_port_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial link
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic mosi_m_o,
  input wire logic mosi_m_oe_n,
  input wire logic mosi_s_o,
  input wire logic mosi_s_oe_n,
  input wire logic miso_o,
  input wire logic miso_oe_n
);
  // ========================================
  // Edge ages and bit count of the frame
  logic [4:0] fall_age_q;
  logic [4:0] sel_age_q;
  logic [2:0] rise_cnt_q;
  logic       sclk_q;
  logic       ssn_q;
  wire        sclk_fall = !sclk && sclk_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fall_age_q <= 5'h1f;
      sel_age_q  <= 5'h00;
      rise_cnt_q <= 3'h0;
      sclk_q     <= 1'b0;
      ssn_q      <= 1'b1;
    end else begin
      sclk_q     <= sclk;
      ssn_q      <= ss_n;
      fall_age_q <= sclk_fall ? 5'h00 : fall_age_q + {4'h0, fall_age_q != 5'h1f};
      sel_age_q  <= ss_n ? 5'h00 : sel_age_q + {4'h0, sel_age_q != 5'h1f};
      rise_cnt_q <= ss_n ? 3'h0 : rise_cnt_q + {2'h0, sclk && !sclk_q && !ssn_q};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ========================================
  // Properties
  desel_float_a: assert property (ss_n [*6] |-> miso_oe_n && mosi_s_oe_n)
    else $error("driver left on while deselected");
  drive_start_a: assert property ($fell(miso_oe_n) |-> !ss_n && sel_age_q <= 5'h08)
    else $error("output driver not started by select");
  miso_fall_a: assert property (!ss_n && !miso_oe_n && sel_age_q > 5'h08 && $changed(miso_o)
    |-> fall_age_q <= 5'h08) else $error("output bit changed away from a falling edge");
  shared_fall_a: assert property (!ss_n && !mosi_s_oe_n && !$past(mosi_s_oe_n)
    && $changed(mosi_s_o) |-> fall_age_q <= 5'h08) else $error("shared pin changed off a fall");
  mst_fall_a: assert property (!ss_n && sel_age_q > 5'h00 && !mosi_m_oe_n && $changed(mosi_m_o)
    |-> sclk_fall || fall_age_q <= 5'h02) else $error("master data changed off a fall");
  clk_idle_a: assert property ($fell(ss_n) |-> $stable(sclk) [*8])
    else $error("clock moved right after select");
  whole_byte_a: assert property ($rose(ss_n) |-> rise_cnt_q == 3'h0)
    else $error("frame ended inside a byte");
  no_fight_a: assert property (!mosi_s_oe_n |-> mosi_m_oe_n)
    else $error("both ends drive the shared pin");
  hd_miso_off_a: assert property (!mosi_s_oe_n |-> miso_oe_n)
    else $error("output pin driven in shared-pin mode");

  fd_frame_c: cover property ($fell(miso_oe_n));
  hd_turn_c: cover property ($fell(mosi_s_oe_n));
  byte_end_c: cover property ($rose(ss_n) && fall_age_q < 5'h1f);
endmodule

`default_nettype wire

// ### tb/test_spi_slave_duplex_port.sv
// Bench joining both serial ends, driving the master user side
`timescale 1ns/1ps
`default_nettype none

module test_spi_slave_duplex_port;
  // ========================================
  // Stimulus and observed signals
  logic       sys_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       cpol = 1'b0;
  logic       fdup = 1'b0;
  logic       cmd_valid = 1'b0;
  logic       tx_valid = 1'b0;
  logic       rx_ready = 1'b1;
  logic [7:0] cmd_byte = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] status_in = 8'h96;
  logic       cmd_ready, tx_ready, rx_valid, status_strobe, full_duplex, wr_strobe;
  logic [7:0] rx_data, status_byte, wr_data, st_v, mo_sh, mi_sh;
  logic [4:0] wr_addr;
  logic [2:0] nb = 3'h0;
  logic       sclk_d, sel_d;
  logic [7:0] mo_q[$];
  logic [7:0] mi_q[$];
  int         n_errors = 0;
  int         checks = 0;
  int         n_st = 0;
  int         n_wr = 0;

  always #2.5 sys_clk = ~sys_clk;

  spi_link_if link ();
  spi_mst_end i_spi_mst_end (.sys_clk(sys_clk), .resetn(resetn), .link(link.mst),
    .cpol(cpol), .full_duplex(fdup), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_byte(cmd_byte), .cmd_len(cmd_len), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .status_strobe(status_strobe), .status_byte(status_byte));
  spi_dev_end i_spi_dev_end (.sys_clk(sys_clk), .resetn(resetn), .link(link.dev),
    .status_in(status_in), .full_duplex(full_duplex), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data));
  spi_slave_duplex_port_properties i_spi_slave_duplex_port_properties (.sys_clk(sys_clk),
    .resetn(resetn), .ss_n(link.ss_n), .sclk(link.sclk), .mosi_m_o(link.mosi_m_o),
    .mosi_m_oe_n(link.mosi_m_oe_n), .mosi_s_o(link.mosi_s_o),
    .mosi_s_oe_n(link.mosi_s_oe_n), .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n));

  // ========================================
  // Wire sniffer: bytes seen on both data wires, taken at sclk rises
  always @(posedge sys_clk) begin
    sclk_d <= link.sclk;
    sel_d  <= !link.ss_n;
    if (status_strobe) begin
      n_st <= n_st + 1;
      st_v <= status_byte;
    end
    if (wr_strobe) n_wr <= n_wr + 1;
    if (link.ss_n) nb <= 3'h0;
    else if (sel_d && link.sclk && !sclk_d) begin
      mo_sh <= {mo_sh[6:0], link.mosi};
      mi_sh <= {mi_sh[6:0], link.miso};
      nb    <= nb + 3'h1;
      if (nb == 3'h7) mo_q.push_back({mo_sh[6:0], link.mosi});
      if (nb == 3'h7) mi_q.push_back({mi_sh[6:0], link.miso});
    end
  end

  // ========================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] cmd(input logic [4:0] a, input logic w);
    return {a, 1'b0, w, 1'b0};
  endfunction

  // One access; writes send wd len times, reads expect ex len times
  task automatic xfer(input logic [7:0] c, input logic [7:0] len, input logic [7:0] wd,
                      input logic [7:0] ex);
    mo_q.delete();
    mi_q.delete();
    cmd_byte  <= c;
    cmd_len   <= len;
    tx_data   <= wd;
    cmd_valid <= 1'b1;
    tx_valid  <= c[1] && len != 8'h00;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    do @(posedge sys_clk); while (link.ss_n !== 1'b0);
    for (int k = 0; k < len; k++) begin
      if (c[1]) begin
        do @(posedge sys_clk); while (tx_ready !== 1'b1);
      end else begin
        do @(posedge sys_clk); while ((rx_valid && rx_ready) !== 1'b1);
        chk(rx_data, ex);
      end
    end
    tx_valid <= 1'b0;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1);
  endtask

  task automatic print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ========================================
  // Scenarios
  task automatic t_reset();
    chk(full_duplex, 1'b0);
    chk(link.miso, 1'b1);
  endtask

  task automatic t_half();
    xfer(cmd(5'h03, 1'b1), 8'h02, 8'hc3, 8'h00);
    chk(mo_q[0], cmd(5'h03, 1'b1));
    chk(mo_q[2], 8'hc3);
    chk(mi_q[0], 8'hff);
    chk(8'(n_wr), 8'h02);
    chk(wr_addr, 5'h03);
    chk(wr_data, 8'hc3);
    chk(8'(n_st), 8'h00);
    xfer(cmd(5'h03, 1'b0), 8'h02, 8'h00, 8'hc3);
    chk(mo_q[2], 8'hc3);
  endtask

  task automatic t_go_full();
    xfer(cmd(spi_duplex_pkg::CTRL_ADDR, 1'b1), 8'h01, 8'h10, 8'h00);
    chk(full_duplex, 1'b1);
    fdup <= 1'b1;
  endtask

  // Writes get status then zeros; a bare command still yields status
  task automatic t_full_write();
    xfer(cmd(5'h05, 1'b1), 8'h01, 8'h5a, 8'h00);
    chk(mi_q[0], 8'h96);
    chk(mi_q[1], 8'h00);
    chk(st_v, 8'h96);
    xfer(cmd(5'h05, 1'b1), 8'h00, 8'h00, 8'h00);
    chk(8'(n_st), 8'h02);
    chk(8'(n_wr), 8'h04);
    chk(link.miso, 1'b1);
  endtask

  // Receiver stalls: the two-entry buffer fills and the clock must stop
  task automatic t_full_stall();
    rx_ready <= 1'b0;
    fork
      xfer(cmd(5'h05, 1'b0), 8'h03, 8'h00, 8'h5a);
      begin
        repeat (1500) @(posedge sys_clk);
        chk(8'(mi_q.size()), 8'h03);
        chk(rx_valid, 1'b1);
        rx_ready <= 1'b1;
      end
    join
    chk(mi_q[3], 8'h5a);
    chk(8'(n_wr), 8'h04);
  endtask

  task automatic t_cpol_one();
    cpol <= 1'b1;
    // Let the idle clock settle at its new level before select falls
    @(posedge sys_clk);
    xfer(cmd(spi_duplex_pkg::STATUS_ADDR, 1'b0), 8'h01, 8'h00, 8'h96);
    chk(mi_q[0], 8'h96);
  endtask

  task automatic t_back_half();
    xfer(cmd(spi_duplex_pkg::CTRL_ADDR, 1'b1), 8'h01, 8'h00, 8'h00);
    chk(full_duplex, 1'b0);
    fdup <= 1'b0;
    xfer(cmd(spi_duplex_pkg::STATUS_ADDR, 1'b0), 8'h01, 8'h00, 8'h96);
    chk(mi_q[1], 8'hff);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_half();
    t_go_full();
    t_full_write();
    t_full_stall();
    t_cpol_one();
    t_back_half();
    print_verdict();
  end

  // Watchdog: about ten times the expected run
  initial begin
    #300000;
    n_errors++;
    print_verdict();
  end
endmodule

`default_nettype wire
